/* File: include/csf_pkg.sv */
// Constants, field layouts and types of the cyclic status frame builder.
// Assumes one synchronous clock domain; shared by the framer and its FIFO.
`default_nettype none
package csf_pkg;
   // ************************************************
   // Frame geometry
   // ************************************************
   localparam int CSF_MAX_BLOCKS = 14;
   localparam int CSF_T1_BLOCKS = 4;
   localparam int CSF_T2_BLOCKS = 8;
   localparam int CSF_T3_BLOCKS = 14;
   localparam int CSF_STATUS_BYTES = 2;
   localparam int CSF_BYTES_PER_BLOCK = 3;
   localparam int CSF_FIFO_DEPTH = 16;
   localparam logic [1:0] CSF_TYPE1 = 2'h1;
   localparam logic [1:0] CSF_TYPE2 = 2'h2;
   localparam logic [1:0] CSF_TYPE3 = 2'h3;

   // ************************************************
   // Block attribute byte layout
   // ************************************************
   localparam int CSF_PB_RANGE = 4;
   localparam int CSF_PB_ON = 5;
   localparam int CSF_PB_AVAIL = 6;
   localparam logic [7:0] CSF_PB_UNUSED = 8'h8c;
   localparam logic [1:0] CSF_ACC_RW = 2'h0;
   localparam logic [1:0] CSF_ACC_RO_RESET = 2'h1;
   localparam logic [1:0] CSF_ACC_RO_FACTORY = 2'h2;
   localparam logic [1:0] CSF_ACC_RO = 2'h3;

   // ************************************************
   // Default data points
   // ************************************************
   localparam logic [15:0] CSF_DP_I1 = 16'h017c;
   localparam logic [15:0] CSF_DP_I2 = 16'h017d;
   localparam logic [15:0] CSF_DP_I3 = 16'h017e;
   localparam logic [15:0] CSF_DP_IMAX = 16'h0176;
   localparam logic [15:0] CSF_DP_IN = 16'h0177;
   localparam logic [15:0] CSF_DP_VLL_MEAN = 16'h00cb;
   localparam logic [15:0] CSF_DP_PF_MEAN = 16'h00a8;
   localparam logic [15:0] CSF_DP_ENERGY = 16'h00ee;
   localparam logic [15:0] CSF_DP_V12 = 16'h00c5;
   localparam logic [15:0] CSF_DP_V23 = 16'h00c6;
   localparam logic [15:0] CSF_DP_V31 = 16'h00c7;
   localparam logic [15:0] CSF_DP_V1N = 16'h00c8;
   localparam logic [15:0] CSF_DP_V2N = 16'h00c9;
   localparam logic [15:0] CSF_DP_V3N = 16'h00ca;
   localparam logic [15:0] CSF_DP_APPARENT = 16'h00d9;

   // ************************************************
   // Types
   // ************************************************
   typedef struct packed {
      logic overload;
      logic springCharged;
      logic uvrCharged;
      logic readyToClose;
      logic [1:0] state;
      logic [1:0] position;
   } csf_status_lo_type;

   typedef struct packed {
      logic loadShed;
      logic [2:0] tripCause;
      logic userInput;
      logic writeUnlocked;
      logic alarm;
      logic threshold;
   } csf_status_hi_type;

   typedef struct packed {
      logic exists;
      logic [1:0] access;
      logic inRange;
      logic optOn;
      logic optAvail;
      logic [31:0] value;
   } csf_lib_answer_type;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } csf_frame_byte_type;

   typedef enum logic [7:0] {
      CSF_IDLE = 8'h01,
      CSF_ST0 = 8'h02,
      CSF_ST1 = 8'h04,
      CSF_LOOK = 8'h08,
      CSF_WAIT = 8'h10,
      CSF_HI = 8'h20,
      CSF_LO = 8'h40,
      CSF_PROP = 8'h80
   } csf_state_type;

   function automatic logic [15:0] csf_default_point(input logic [1:0] bt, input int idx);
      logic [15:0] p;
      p = 16'h0000;
      case (idx)
         0: p = CSF_DP_I1;
         1: p = CSF_DP_I2;
         2: p = CSF_DP_I3;
         3: p = CSF_DP_IMAX;
         4: p = CSF_DP_IN;
         5: p = (bt == CSF_TYPE2) ? CSF_DP_VLL_MEAN : CSF_DP_V12;
         6: p = (bt == CSF_TYPE2) ? CSF_DP_PF_MEAN : CSF_DP_V23;
         7: p = (bt == CSF_TYPE2) ? CSF_DP_ENERGY : CSF_DP_V31;
         8: p = CSF_DP_V1N;
         9: p = CSF_DP_V2N;
         10: p = CSF_DP_V3N;
         11: p = CSF_DP_PF_MEAN;
         12: p = CSF_DP_ENERGY;
         13: p = CSF_DP_APPARENT;
         default: p = 16'h0000;
      endcase
      return p;
   endfunction : csf_default_point
endpackage : csf_pkg
`default_nettype wire

/* File: hdl/csf_fifo.sv */
// Byte FIFO between the frame assembler and the fieldbus transmitter.
// Assumes one clock; read data leave through a register.
`default_nettype none
module csf_fifo
   import csf_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign inReady = (count_reg != (AW+1)'(DEPTH));
   assign push = inValid && inReady;
   // Refill the output register whenever it is empty or being taken
   assign pop = (count_reg != '0) && (!outValid || outReady);

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         outValid <= 1'b0;
         outData <= '0;
      end else if (pop) begin
         outValid <= 1'b1;
         outData <= mem[rdPtr_reg];
      end else if (outReady) begin
         outValid <= 1'b0;
      end
   end
endmodule : csf_fifo
`default_nettype wire

/* File: hdl/csf_frame_builder.sv */
// Cyclic input frame assembler: status word, data blocks, attribute bytes.
// Assumes a data library that answers a point lookup some cycles later and
// a transmitter that drains the byte stream with valid/ready.
`default_nettype none
module csf_frame_builder
   import csf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [1:0] basicType,
   input wire logic exchReq,
   input wire csf_status_lo_type statusLo,
   input wire csf_status_hi_type statusHi,
   input wire logic asgValid,
   input wire logic [3:0] asgIndex,
   input wire logic [15:0] asgPoint,
   output logic libReq,
   output logic [15:0] libPoint,
   input wire logic libAck,
   input wire csf_lib_answer_type libAns,
   output logic exchBusy,
   output logic frameValid,
   input wire logic frameReady,
   output csf_frame_byte_type frameByte
);
   // ************************************************
   // Block configuration
   // ************************************************
   logic [1:0] type_reg;
   logic [1:0] type_next;
   logic [3:0] blockCount;
   logic [15:0] point_reg [CSF_MAX_BLOCKS];
   logic [5:0] attr_reg [CSF_MAX_BLOCKS];
   csf_state_type state_reg;
   logic [3:0] blkIdx_reg;
   logic pushReady;
   logic pushValid;
   logic reload;

   // Unknown codes fall back to the smallest frame
   assign type_next = (basicType == 2'h0) ? CSF_TYPE1 : basicType;
   // Type changes only between frames so a frame never mixes layouts
   assign reload = (state_reg == CSF_IDLE) && (type_next != type_reg);

   always_comb begin
      case (type_reg)
         CSF_TYPE2: blockCount = 4'(CSF_T2_BLOCKS);
         CSF_TYPE3: blockCount = 4'(CSF_T3_BLOCKS);
         default: blockCount = 4'(CSF_T1_BLOCKS);
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         type_reg <= CSF_TYPE1;
      end else if (reload) begin
         type_reg <= type_next;
      end
   end

   // One entry per block position: default point, master's choice, attributes
   for (genvar i = 0; i < CSF_MAX_BLOCKS; i++) begin : gBlock
      logic hit;
      assign hit = asgValid && (asgIndex == 4'(i)) && (4'(i) < blockCount);
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            point_reg[i] <= csf_default_point(CSF_TYPE1, i);
            attr_reg[i] <= '0;
         end else begin
            if (reload) begin
               point_reg[i] <= csf_default_point(type_next, i);
               attr_reg[i] <= '0;
            end else if (hit) begin
               point_reg[i] <= asgPoint;
               attr_reg[i] <= '0;
            end
            // Fresh lookup overrides a stale attribute of the same block
            if (libAck && (state_reg == CSF_WAIT) && (blkIdx_reg == 4'(i))) begin
               attr_reg[i] <= {libAns.exists, libAns.access,
                  libAns.inRange, libAns.optOn, libAns.optAvail};
            end
         end
      end
   end

   // ************************************************
   // Frame sequencer
   // ************************************************
   logic [15:0] value_reg;
   csf_status_lo_type statLo_reg;
   csf_status_hi_type statHi_reg;
   logic [7:0] pushData;
   logic pushLast;
   logic [5:0] byteCnt_reg;
   logic [5:0] curAttr;
   logic [7:0] curProp;

   assign curAttr = attr_reg[blkIdx_reg];

   always_comb begin
      curProp = 8'h00;
      curProp[1:0] = curAttr[4:3];
      if (curAttr[5]) begin
         curProp[CSF_PB_RANGE] = curAttr[2];
         curProp[CSF_PB_ON] = curAttr[1];
         curProp[CSF_PB_AVAIL] = curAttr[0];
      end
      // Bits 2, 3 and 7 stay zero from the reset value above
   end

   always_comb begin
      pushValid = 1'b1;
      pushLast = 1'b0;
      case (state_reg)
         CSF_ST0: pushData = statLo_reg;
         CSF_ST1: pushData = statHi_reg;
         CSF_HI: pushData = value_reg[15:8];
         CSF_LO: pushData = value_reg[7:0];
         CSF_PROP: begin
            pushData = curProp;
            pushLast = (blkIdx_reg == blockCount - 4'h1);
         end
         default: begin
            pushData = 8'h00;
            pushValid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= CSF_IDLE;
         blkIdx_reg <= '0;
      end else begin
         case (state_reg)
            CSF_IDLE: begin
               if (exchReq && !reload) begin
                  state_reg <= CSF_ST0;
               end
            end
            CSF_ST0: begin
               if (pushReady) begin
                  state_reg <= CSF_ST1;
               end
            end
            CSF_ST1: begin
               if (pushReady) begin
                  state_reg <= CSF_LOOK;
                  blkIdx_reg <= '0;
               end
            end
            CSF_LOOK: state_reg <= CSF_WAIT;
            CSF_WAIT: begin
               if (libAck) begin
                  state_reg <= CSF_HI;
               end
            end
            CSF_HI: begin
               if (pushReady) begin
                  state_reg <= CSF_LO;
               end
            end
            CSF_LO: begin
               if (pushReady) begin
                  if (blkIdx_reg == blockCount - 4'h1) begin
                     state_reg <= CSF_PROP;
                     blkIdx_reg <= '0;
                  end else begin
                     state_reg <= CSF_LOOK;
                     blkIdx_reg <= blkIdx_reg + 4'h1;
                  end
               end
            end
            CSF_PROP: begin
               if (pushReady) begin
                  if (pushLast) begin
                     state_reg <= CSF_IDLE;
                  end else begin
                     blkIdx_reg <= blkIdx_reg + 4'h1;
                  end
               end
            end
            default: state_reg <= CSF_IDLE;
         endcase
      end
   end

   // Status is frozen at the start so both bytes describe one instant
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         statLo_reg <= '0;
         statHi_reg <= '0;
      end else if (state_reg == CSF_IDLE && exchReq && !reload) begin
         statLo_reg <= statusLo;
         statHi_reg <= statusHi;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         value_reg <= '0;
      end else if (state_reg == CSF_WAIT && libAck) begin
         value_reg <= libAns.value[15:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         libReq <= 1'b0;
         libPoint <= '0;
      end else begin
         libReq <= (state_reg == CSF_LOOK);
         if (state_reg == CSF_LOOK) begin
            libPoint <= point_reg[blkIdx_reg];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         exchBusy <= 1'b0;
      end else begin
         exchBusy <= (state_reg != CSF_IDLE);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         byteCnt_reg <= '0;
      end else if (state_reg == CSF_IDLE) begin
         byteCnt_reg <= '0;
      end else if (pushValid && pushReady) begin
         byteCnt_reg <= byteCnt_reg + 6'h01;
      end
   end

   // ************************************************
   // Output buffer
   // ************************************************
   // The sequencer stalls on a full buffer, so a slow drain never drops bytes
   csf_fifo #(
      .WIDTH(9),
      .DEPTH(CSF_FIFO_DEPTH)
   ) uFifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData({pushLast, pushData}),
      .outValid(frameValid),
      .outReady(frameReady),
      .outData(frameByte)
   );

   // ************************************************
   // Checks
   // ************************************************
   frame_length_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_PROP && pushReady && pushLast) |->
      byteCnt_reg == 6'(CSF_STATUS_BYTES) + 6'(CSF_BYTES_PER_BLOCK) * 6'(blockCount) - 6'h01)
      else $error("frame length does not match basic type");

   status_first_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pushValid && byteCnt_reg == 6'h00) |-> state_reg == CSF_ST0)
      else $error("first frame byte is not status");

   status_word_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_ST0 && pushReady) |=> (pushData == statHi_reg) && pushValid)
      else $error("status bytes out of order");

   truncate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_WAIT && libAck) |=>
      (state_reg == CSF_HI) && pushData == $past(libAns.value[15:8]))
      else $error("block high byte not taken from low word");

   low_byte_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_HI && pushReady) |=>
      state_reg == CSF_LO && pushData == value_reg[7:0])
      else $error("block low byte does not follow high byte");

   prop_unused_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_PROP) |-> (pushData & CSF_PB_UNUSED) == 8'h00)
      else $error("unused attribute bits set");

   prop_missing_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_PROP && !curAttr[5]) |-> pushData[6:4] == 3'h0)
      else $error("missing point reported available");

   assign_block_a: assert property (@(posedge clk_sys) disable iff (rst)
      (asgValid && !reload && asgIndex < blockCount) |=>
      point_reg[$past(asgIndex)] == $past(asgPoint))
      else $error("block reassignment not stored");

   lookup_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_LOOK) |=> libReq && libPoint == $past(point_reg[blkIdx_reg]))
      else $error("lookup uses wrong data point");

   attr_refresh_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_WAIT && libAck) |=> attr_reg[$past(blkIdx_reg)] ==
      $past({libAns.exists, libAns.access, libAns.inRange, libAns.optOn, libAns.optAvail}))
      else $error("attribute not refreshed from lookup");

   prop_access_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_PROP) |-> pushData[1:0] == attr_reg[blkIdx_reg][4:3])
      else $error("attribute access class wrong");

   prop_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_PROP && curAttr[5]) |->
      pushData[6:4] == {curAttr[0], curAttr[1], curAttr[2]})
      else $error("attribute flags misplaced");

   status_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_IDLE && exchReq && !reload) |=>
      statLo_reg == $past(statusLo) && statHi_reg == $past(statusHi))
      else $error("status snapshot not taken at frame start");

   exch_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == CSF_IDLE && exchReq && !reload) |=> state_reg == CSF_ST0 ##1 exchBusy)
      else $error("exchange did not start with status");
endmodule : csf_frame_builder
`default_nettype wire

/* File: sim/csf_lib_model.sv */
// Far-side model: data library answering point lookups, and the master's byte sink.
// Assumes the frame builder's lookup handshake and a valid/ready byte stream.
`default_nettype none
module csf_lib_model
   import csf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slowLib,
   input wire logic [1:0] sinkMode,
   input wire logic libReq,
   input wire logic [15:0] libPoint,
   output logic libAck,
   output csf_lib_answer_type libAns,
   output logic frameReady
);
   // ************************************************
   // Library lookup
   // ************************************************
   logic [15:0] pendPoint;
   logic pending;
   logic [3:0] waitCnt;
   logic [1:0] phase;

   // High half differs from low half so that truncation is visible
   function automatic csf_lib_answer_type lib_answer(input logic [15:0] p);
      csf_lib_answer_type a;
      a.exists = !(p >= CSF_DP_V12 && p <= CSF_DP_V3N);
      a.access = p[1:0];
      a.inRange = p[2];
      a.optOn = p[3];
      a.optAvail = ~p[5];
      a.value = {~p, p ^ 16'h5a5a};
      return a;
   endfunction : lib_answer

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         libAck <= 1'b0;
         libAns <= '0;
         pending <= 1'b0;
         waitCnt <= 4'h0;
      end else if (libReq && !slowLib) begin
         libAck <= 1'b1;
         libAns <= lib_answer(libPoint);
      end else if (libReq) begin
         pending <= 1'b1;
         pendPoint <= libPoint;
         waitCnt <= 4'h5;
         libAck <= 1'b0;
         libAns <= ~libAns;
      end else if (pending && waitCnt == 4'h0) begin
         pending <= 1'b0;
         libAck <= 1'b1;
         libAns <= lib_answer(pendPoint);
      end else begin
         // Answer lines toggle between the last answer and its complement once the acknowledge drops
         if (pending) begin
            waitCnt <= waitCnt - 4'h1;
         end
         libAck <= 1'b0;
         libAns <= ~libAns;
      end
   end

   // ************************************************
   // Byte sink: always ready, ready two of three, or stalled
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase <= 2'h0;
      end else begin
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      end
   end

   assign frameReady = (sinkMode == 2'h0) || (sinkMode == 2'h1 && phase != 2'h0);
endmodule : csf_lib_model
`default_nettype wire

/* File: sim/cyclic_status_frame_builder_tb.sv */
// Self-checking bench for the cyclic status frame builder.
// Assumes csf_pkg and the library/sink model; one 100 MHz clock.
`default_nettype none
module cyclic_status_frame_builder_tb
   import csf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************
   // Signals
   // ************************************************
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] basicType = 2'h1;
   logic exchReq = 1'b0;
   csf_status_lo_type statusLo = '0;
   csf_status_hi_type statusHi = '0;
   logic asgValid = 1'b0;
   logic [3:0] asgIndex = 4'h0;
   logic [15:0] asgPoint = 16'h0000;
   logic libReq, libAck, exchBusy, frameValid, frameReady;
   logic [15:0] libPoint;
   csf_lib_answer_type libAns;
   csf_frame_byte_type frameByte;
   logic slowLib = 1'b0;
   logic [1:0] sinkMode = 2'h0;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   csf_frame_byte_type rxQ[$];
   logic [15:0] expPts[14];

   always #5 clk_sys = ~clk_sys;

   csf_frame_builder u_dut (.clk_sys(clk_sys), .rst(rst), .basicType(basicType),
      .exchReq(exchReq), .statusLo(statusLo), .statusHi(statusHi), .asgValid(asgValid),
      .asgIndex(asgIndex), .asgPoint(asgPoint), .libReq(libReq), .libPoint(libPoint),
      .libAck(libAck), .libAns(libAns), .exchBusy(exchBusy), .frameValid(frameValid),
      .frameReady(frameReady), .frameByte(frameByte));

   csf_lib_model u_lib (.clk_sys(clk_sys), .rst(rst), .slowLib(slowLib),
      .sinkMode(sinkMode), .libReq(libReq), .libPoint(libPoint), .libAck(libAck),
      .libAns(libAns), .frameReady(frameReady));

   always @(posedge clk_sys) begin
      if (frameValid === 1'b1 && frameReady === 1'b1) begin
         rxQ.push_back(frameByte);
      end
   end

   // ************************************************
   // Checking and closing
   // ************************************************
   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // Sized for the whole sequence with stalls and the slow library
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         $display("CHECK FAILED t=%0t run did not finish", $time);
         results();
      end
   end

   // ************************************************
   // Stimulus helpers
   // ************************************************
   task automatic set_type(input logic [1:0] bt);
      @(posedge clk_sys);
      basicType <= bt;
      repeat (4) @(posedge clk_sys);
      expPts = '{CSF_DP_I1, CSF_DP_I2, CSF_DP_I3, CSF_DP_IMAX, CSF_DP_IN,
         CSF_DP_V12, CSF_DP_V23, CSF_DP_V31, CSF_DP_V1N, CSF_DP_V2N, CSF_DP_V3N,
         CSF_DP_PF_MEAN, CSF_DP_ENERGY, CSF_DP_APPARENT};
      if (bt == CSF_TYPE2) begin
         expPts[5] = CSF_DP_VLL_MEAN;
         expPts[6] = CSF_DP_PF_MEAN;
         expPts[7] = CSF_DP_ENERGY;
      end
   endtask : set_type

   task automatic assign_point(input logic [3:0] idx, input logic [15:0] p, input int n);
      @(posedge clk_sys);
      asgValid <= 1'b1;
      asgIndex <= idx;
      asgPoint <= p;
      @(posedge clk_sys);
      asgValid <= 1'b0;
      if (idx < n) begin
         expPts[idx] = p;
      end
   endtask : assign_point

   // Runs one exchange, switches the sink to modeAfter after hold cycles, then judges every byte
   task automatic run_frame(input int n, input int hold, input logic [1:0] modeAfter);
      logic [8:0] expLo, expHi, expAttr, w;
      logic [15:0] p;
      logic ex;
      int k;
      rxQ.delete();
      @(posedge clk_sys);
      exchReq <= 1'b1;
      @(posedge clk_sys);
      exchReq <= 1'b0;
      expLo = {1'b0, statusLo.overload, statusLo.springCharged, statusLo.uvrCharged,
         statusLo.readyToClose, statusLo.state, statusLo.position};
      expHi = {1'b0, statusHi.loadShed, statusHi.tripCause, statusHi.userInput,
         statusHi.writeUnlocked, statusHi.alarm, statusHi.threshold};
      for (k = 0; k < 3000; k++) begin
         @(posedge clk_sys);
         #1;
         if (k == 0) begin
            check({8'h00, exchBusy}, 9'h001, "busy during exchange");
         end
         if (k == hold) begin
            if (hold > 0) begin
               check({8'h00, frameValid}, 9'h001, "valid held under stall");
               check(9'(rxQ.size()), 9'h000, "no byte taken under stall");
            end
            sinkMode <= modeAfter;
         end
         if (rxQ.size() > 0 && rxQ[$].last === 1'b1 && exchBusy === 1'b0) begin
            break;
         end
      end
      check({8'h00, exchBusy}, 9'h000, "idle after frame");
      check(9'(rxQ.size()), 9'(CSF_STATUS_BYTES + 3 * n), "frame length");
      for (k = 0; k < rxQ.size(); k++) begin
         check({8'h00, rxQ[k].last}, {8'h00, k == rxQ.size() - 1}, "last flag");
      end
      if (rxQ.size() == 2 + 3 * n) begin
         check(rxQ[0].data, expLo, "status byte n");
         check(rxQ[1].data, expHi, "status byte n+1");
         for (k = 0; k < n; k++) begin
            p = expPts[k];
            ex = !(p >= CSF_DP_V12 && p <= CSF_DP_V3N);
            w = {1'b0, p[15:8] ^ 8'h5a};
            check(rxQ[2 + 2 * k].data, w, "block high byte");
            check(rxQ[3 + 2 * k].data, {1'b0, p[7:0] ^ 8'h5a}, "block low byte");
            if (ex) begin
               expAttr = {2'b00, ~p[5], p[3], p[2], 2'b00, p[1:0]};
               check(rxQ[2 + 2 * n + k].data, expAttr, "attribute byte");
            end else begin
               check(rxQ[2 + 2 * n + k].data & 9'h0fc, 9'h000, "not available");
            end
         end
      end
   endtask : run_frame

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic test_status_type1();
      int i;
      for (i = 0; i < 7; i++) begin
         @(posedge clk_sys);
         statusLo <= csf_status_lo_type'(8'(i * 8'h25 + 8'h13));
         statusHi <= csf_status_hi_type'({i[0], i[2:0], i[1], i[2], ~i[0], i[0]});
         run_frame(CSF_T1_BLOCKS, 0, 2'h0);
      end
      $display("test status_type1 done");
   endtask : test_status_type1

   task automatic test_type2_slow();
      set_type(CSF_TYPE2);
      slowLib <= 1'b1;
      sinkMode <= 2'h1;
      run_frame(CSF_T2_BLOCKS, 0, 2'h1);
      slowLib <= 1'b0;
      $display("test type2_slow done");
   endtask : test_type2_slow

   task automatic test_type3_fifo();
      set_type(CSF_TYPE3);
      sinkMode <= 2'h2;
      // Long stall fills the 16-word buffer before any byte leaves
      run_frame(CSF_T3_BLOCKS, 80, 2'h0);
      $display("test type3_fifo done");
   endtask : test_type3_fifo

   task automatic test_reassign();
      assign_point(4'h5, 16'h1234, CSF_T3_BLOCKS);
      assign_point(4'hd, CSF_DP_V23, CSF_T3_BLOCKS);
      assign_point(4'he, 16'h0abc, CSF_T3_BLOCKS);
      run_frame(CSF_T3_BLOCKS, 0, 2'h1);
      // Code 0 must fall back to the four-block layout
      set_type(2'h0);
      assign_point(4'h3, 16'h025b, CSF_T1_BLOCKS);
      assign_point(4'h4, 16'h0300, CSF_T1_BLOCKS);
      run_frame(CSF_T1_BLOCKS, 0, 2'h0);
      $display("test reassign done");
   endtask : test_reassign

   initial begin
      set_type(CSF_TYPE1);
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      test_status_type1();
      test_type2_slow();
      test_type3_fifo();
      test_reassign();
      results();
   end
endmodule : cyclic_status_frame_builder_tb
`default_nettype wire
